// ---- design/bias_seq_pkg.sv ----
package bias_seq_pkg;

  // Register offsets
  localparam logic [7:0] PANEL_BIAS_CONFIG_OFS = 8'h07;
  localparam logic [7:0] STEP_TIMING_OFS       = 8'h08;
  localparam logic [7:0] ORDER_CONFIG_OFS      = 8'h09;

  // Field positions in panel_bias_config
  localparam int UNIPOLAR_SEL_BIT   = 0;
  localparam int RAIL_STATUS_LSB    = 4;

  // Field positions in step_timing, each gap 2 bits in ms
  localparam int STEP_GAP_A_LSB     = 0;
  localparam int STEP_GAP_B_LSB     = 2;
  localparam int STEP_GAP_C_LSB     = 4;
  localparam int STEP_GAP_W         = 2;

  // Field positions in order_config
  localparam int ORDER_SEL_LSB      = 0;
  localparam int ORDER_SEL_W        = 3;
  localparam int PF_THRESH_SEL_BIT  = 3;
  localparam int RAMP_SEL_LSB       = 4;
  localparam int RAMP_SEL_W         = 2;

  // Values after reset, and masks of the writable bits
  localparam logic [7:0] PANEL_BIAS_CONFIG_RST = 8'h00;
  localparam logic [7:0] STEP_TIMING_RST       = 8'h00;
  localparam logic [7:0] ORDER_CONFIG_RST      = 8'h02;
  localparam logic [7:0] PANEL_BIAS_WR_MASK    = 8'h01;
  localparam logic [7:0] ORDER_CONFIG_WR_MASK  = 8'h3f;

  // Nonvolatile image layout
  localparam int NV_W              = 25;
  localparam int NV_PANEL_LSB      = 0;
  localparam int NV_TIMING_LSB     = 8;
  localparam int NV_ORDER_LSB      = 16;
  localparam int NV_AUTORUN_BIT    = 24;

  // Rail positions in the enable vector
  localparam int RAIL_POS = 0;
  localparam int RAIL_NEG = 1;
  localparam int RAIL_GL  = 2;
  localparam int RAIL_GH  = 3;

  // Timing
  localparam int CLOCK_PERIOD_NS      = 10;
  localparam int MS_IN_NS             = 1000000;
  localparam int MS_CYCLES            = MS_IN_NS / CLOCK_PERIOD_NS;
  localparam int CORE_OFF_DELAY_MS    = 200;
  localparam int DOWN_MIN_GAP_MS      = 1;
  localparam int ILIM_STEPS           = 8;

  // Sequencer states
  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_BOOST = 7'b0000010,
    ST_UP    = 7'b0000100,
    ST_ON    = 7'b0001000,
    ST_DOWN  = 7'b0010000,
    ST_HOLD  = 7'b0100000,
    ST_SHUT  = 7'b1000000
  } seq_state_t;

endpackage

// ---- design/ms_tick_divider.sv ----
`timescale 1ns/1ns
module ms_tick_divider #(
  parameter int CYCLES_PER_MS = 100000
) (
  input  wire logic clock,
  input  wire logic reset_n,
  output logic      ms_tick
);

  logic [31:0] count_q;

  // Free running divider, one pulse per millisecond
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      count_q <= 32'h0;
      ms_tick <= 1'b0;
    end else if (count_q == 32'(CYCLES_PER_MS - 1)) begin
      count_q <= 32'h0;
      ms_tick <= 1'b1;
    end else begin
      count_q <= count_q + 32'h1;
      ms_tick <= 1'b0;
    end
  end

endmodule

// ---- design/tft_bias_power_sequencer.sv ----
// Functional notes
// - Run only while main supply and core rail are above their lockouts.
// - Power-fail low when supply under threshold, until core rail drops out.
// - Threshold select bit: 0 gives 2.5 V default, 1 gives 2.4 V; storable.
// - Backlight works only when LED and driver supplies pass lockout.
// - Unipolar bit 1 leaves negative rail unused; 0 default is bipolar.
// - Positive rail current limit rises in eight steps, each 1/8 to 1/2 ms long as set by ramp select.
// - Gate-high and gate-low targets come from separate 6-bit fields.
// - Launch bit 1 enables the four rails in the selected order.
// - Stored autorun bit starts power-up when enable pin goes high.
// - Three-bit order select gives eight power-up orders, default 010.
// - Power-down is reverse order with gaps taken third, second, first.
// - Three step gaps in ms come from step timing; zero is fastest.
// - In unipolar mode the negative slot is kept but never turned on.
// - Backlight enabled once every bias rail is power-good.
// - Power-down ignores rail voltages; zero gaps still spaced by 1 ms.
// - Store command saves current sequence configuration to nonvolatile bits.
// - Enable-pin power-down turns core rail off 200 ms after, then shutdown.
// - Launch-bit power-down keeps core rail powered.
// - Boost rail comes up first; rails follow after its soft-start.
// - Enable pin high enables device, low leads to shutdown.
`timescale 1ns/1ns
module tft_bias_power_sequencer
  import bias_seq_pkg::*;
#(
  parameter int CYCLES_PER_MS = MS_CYCLES
) (
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [7:0]        reg_rdata,
  input  wire logic              launch,
  input  wire logic              nv_store_cmd,
  input  wire logic [NV_W-1:0]   nv_image_in,
  output logic      [NV_W-1:0]   nv_image,
  input  wire logic              enable_pin,
  input  wire logic              main_supply_ok,
  input  wire logic              core_rail_ok,
  input  wire logic              main_below_2v5,
  input  wire logic              main_below_2v4,
  input  wire logic              led_supply_ok,
  input  wire logic              driver_supply_ok,
  input  wire logic              boost_soft_start_done,
  input  wire logic [3:0]        rail_power_good,
  input  wire logic [5:0]        gate_high_level_in,
  input  wire logic [5:0]        gate_low_level_in,
  output logic      [5:0]        gate_high_level,
  output logic      [5:0]        gate_low_level,
  output logic                   boost_rail_en,
  output logic      [3:0]        rail_en,
  output logic      [3:0]        pos_ilim_step,
  output logic                   core_rail_en,
  output logic                   backlight_en,
  output logic                   power_fail_o,
  output logic                   power_fail_oe,
  output logic                   seq_busy
);

  logic [7:0]      panel_bias_config_q;
  logic [7:0]      step_timing_q;
  logic [7:0]      order_config_q;
  logic [NV_W-1:0] nv_q;
  logic            nv_loaded_q;
  seq_state_t      state_q;
  logic [3:0]      en_q;
  logic [1:0]      step_q;
  logic [1:0]      dn_k_q;
  logic [7:0]      ms_cnt_q;
  logic            by_pin_q;
  logic            enable_pin_q;
  logic            autorun_q;
  logic            pf_q;
  logic            ms_tick;
  logic [31:0]     ramp_cnt_q;
  logic            pos_on_q;
  logic            bias_good_q;

  logic            run_ok;
  logic            start_req;
  logic            unipolar;
  logic [2:0]      order_sel;
  logic [1:0]      gap_a;
  logic [1:0]      gap_b;
  logic [1:0]      gap_c;
  logic [7:0]      up_target;
  logic [7:0]      dn_target;
  logic [1:0]      down_start;
  logic [31:0]     ramp_period;
  logic            pos_out;

  // Rails enabled at a given step for a given order
  function automatic logic [3:0] slot_mask(input logic [2:0] sel, input logic [1:0] idx);
    logic [15:0] tbl;
    tbl = 16'h0;
    unique case (sel)
      3'h0: tbl = 16'h8421;
      3'h1: tbl = 16'h4821;
      3'h2: tbl = 16'h8412;
      3'h3: tbl = 16'h4812;
      3'h4: tbl = 16'h8142;
      3'h5: tbl = 16'h1284;
      3'h6: tbl = 16'h0843;
      3'h7: tbl = 16'h0483;
    endcase
    return tbl[idx*4 +: 4];
  endfunction

  ms_tick_divider #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) u_ms_tick (
    .clock   (clock),
    .reset_n (reset_n),
    .ms_tick (ms_tick)
  );

  // Configuration fields
  assign unipolar  = panel_bias_config_q[UNIPOLAR_SEL_BIT];
  assign order_sel = order_config_q[ORDER_SEL_LSB +: ORDER_SEL_W];
  assign gap_a     = step_timing_q[STEP_GAP_A_LSB +: STEP_GAP_W];
  assign gap_b     = step_timing_q[STEP_GAP_B_LSB +: STEP_GAP_W];
  assign gap_c     = step_timing_q[STEP_GAP_C_LSB +: STEP_GAP_W];

  // Device alive and sequence request
  assign run_ok    = main_supply_ok & core_rail_ok;
  assign start_req = enable_pin & (launch | autorun_q);

  // Gap after each power-up step: a, b, c
  always_comb begin
    up_target = 8'h0;
    unique case (step_q)
      2'd0: up_target = {6'h0, gap_a};
      2'd1: up_target = {6'h0, gap_b};
      2'd2: up_target = {6'h0, gap_c};
      2'd3: up_target = 8'h0;
    endcase
  end

  // Gap after each power-down step: c, b, a, never under 1 ms
  always_comb begin
    dn_target = 8'h0;
    unique case (dn_k_q)
      2'd0: dn_target = {6'h0, gap_c};
      2'd1: dn_target = {6'h0, gap_b};
      2'd2: dn_target = {6'h0, gap_a};
      2'd3: dn_target = {6'h0, gap_a};
    endcase
    if (dn_target < 8'(DOWN_MIN_GAP_MS)) begin
      dn_target = 8'(DOWN_MIN_GAP_MS);
    end
  end

  // Skip an empty last slot so power-down starts at slot 2 at once; reverse gaps still begin with c
  assign down_start = (step_q == 2'd3 && slot_mask(order_sel, 2'd3) == 4'h0) ? 2'd2 : step_q;

  // Register writes and nonvolatile image
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      nv_q                <= nv_image_in;
      nv_loaded_q         <= 1'b0;
      panel_bias_config_q <= PANEL_BIAS_CONFIG_RST;
      step_timing_q       <= STEP_TIMING_RST;
      order_config_q      <= ORDER_CONFIG_RST;
    end else if (!nv_loaded_q) begin
      // First cycle after release takes the stored configuration
      nv_loaded_q         <= 1'b1;
      panel_bias_config_q <= nv_q[NV_PANEL_LSB +: 8] & PANEL_BIAS_WR_MASK;
      step_timing_q       <= nv_q[NV_TIMING_LSB +: 8];
      order_config_q      <= nv_q[NV_ORDER_LSB +: 8] & ORDER_CONFIG_WR_MASK;
    end else begin
      if (reg_write && reg_addr == PANEL_BIAS_CONFIG_OFS) begin
        panel_bias_config_q <= reg_wdata & PANEL_BIAS_WR_MASK;
      end
      if (reg_write && reg_addr == STEP_TIMING_OFS) begin
        step_timing_q <= reg_wdata;
      end
      if (reg_write && reg_addr == ORDER_CONFIG_OFS) begin
        order_config_q <= reg_wdata & ORDER_CONFIG_WR_MASK;
      end
      if (nv_store_cmd) begin
        nv_q <= {launch, order_config_q, step_timing_q, panel_bias_config_q};
      end
    end
  end

  assign nv_image = nv_q;

  // Register reads, rail state shown in the upper config bits
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      unique case (reg_addr)
        PANEL_BIAS_CONFIG_OFS: reg_rdata <= {rail_en, panel_bias_config_q[3:0]};
        STEP_TIMING_OFS:       reg_rdata <= step_timing_q;
        ORDER_CONFIG_OFS:      reg_rdata <= order_config_q;
        default:               reg_rdata <= 8'h00;
      endcase
    end
  end

  // Autorun armed on rising enable pin; pin high at reset release counts as a rise
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      enable_pin_q <= 1'b0;
      autorun_q    <= 1'b0;
    end else begin
      enable_pin_q <= enable_pin;
      if (!enable_pin) begin
        autorun_q <= 1'b0;
      end else if (!enable_pin_q && nv_q[NV_AUTORUN_BIT]) begin
        autorun_q <= 1'b1;
      end
    end
  end

  // Power-up and power-down sequencer
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_q       <= ST_IDLE;
      en_q          <= 4'h0;
      step_q        <= 2'd0;
      dn_k_q        <= 2'd0;
      ms_cnt_q      <= 8'h0;
      by_pin_q      <= 1'b0;
      boost_rail_en <= 1'b0;
      core_rail_en  <= 1'b1;
    end else if (!run_ok) begin
      state_q       <= ST_IDLE;
      en_q          <= 4'h0;
      boost_rail_en <= 1'b0;
    end else begin
      if (ms_tick && ms_cnt_q != 8'hff) begin
        ms_cnt_q <= ms_cnt_q + 8'h1;
      end
      unique case (state_q)
        ST_IDLE: begin
          en_q          <= 4'h0;
          boost_rail_en <= 1'b0;
          if (!enable_pin) begin
            state_q  <= ST_HOLD;
            ms_cnt_q <= 8'h0;
          end else if (start_req && nv_loaded_q) begin
            state_q       <= ST_BOOST;
            boost_rail_en <= 1'b1;
          end
        end
        ST_BOOST: begin
          if (!start_req) begin
            state_q       <= ST_IDLE;
            boost_rail_en <= 1'b0;
          end else if (boost_soft_start_done) begin
            en_q     <= slot_mask(order_sel, 2'd0);
            step_q   <= 2'd0;
            ms_cnt_q <= 8'h0;
            state_q  <= ST_UP;
          end
        end
        ST_UP, ST_ON: begin
          if (!start_req) begin
            state_q  <= ST_DOWN;
            step_q   <= down_start;
            en_q     <= en_q & ~slot_mask(order_sel, down_start);
            dn_k_q   <= 2'd0;
            ms_cnt_q <= 8'h0;
            by_pin_q <= !enable_pin;
          end else if (state_q == ST_UP && ms_cnt_q >= up_target) begin
            if (step_q == 2'd3) begin
              state_q <= ST_ON;
            end else begin
              step_q   <= step_q + 2'd1;
              en_q     <= en_q | slot_mask(order_sel, step_q + 2'd1);
              ms_cnt_q <= 8'h0;
            end
          end
        end
        ST_DOWN: begin
          if (step_q == 2'd0) begin
            boost_rail_en <= 1'b0;
            ms_cnt_q      <= 8'h0;
            state_q       <= by_pin_q ? ST_HOLD : ST_IDLE;
          end else if (ms_cnt_q >= dn_target) begin
            step_q   <= step_q - 2'd1;
            en_q     <= en_q & ~slot_mask(order_sel, step_q - 2'd1);
            dn_k_q   <= dn_k_q + 2'd1;
            ms_cnt_q <= 8'h0;
          end
        end
        ST_HOLD: begin
          if (enable_pin) begin
            state_q <= ST_IDLE;
          end else if (ms_cnt_q >= 8'(CORE_OFF_DELAY_MS)) begin
            core_rail_en <= 1'b0;
            state_q      <= ST_SHUT;
          end
        end
        ST_SHUT: begin
          if (enable_pin) begin
            core_rail_en <= 1'b1;
            state_q      <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Negative rail slot kept but held off in unipolar mode
  always_comb begin
    rail_en           = en_q;
    rail_en[RAIL_NEG] = en_q[RAIL_NEG] & ~unipolar;
  end
  assign pos_out  = rail_en[RAIL_POS];
  assign seq_busy = (state_q == ST_BOOST) || (state_q == ST_UP) || (state_q == ST_DOWN);

  // Positive switch current limit ramp
  assign ramp_period = (32'(order_config_q[RAMP_SEL_LSB +: RAMP_SEL_W]) + 32'h1)
                       * 32'(CYCLES_PER_MS) / 32'(ILIM_STEPS);
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pos_on_q      <= 1'b0;
      ramp_cnt_q    <= 32'h0;
      pos_ilim_step <= 4'h0;
    end else begin
      pos_on_q <= pos_out;
      if (!pos_out) begin
        pos_ilim_step <= 4'h0;
        ramp_cnt_q    <= 32'h0;
      end else if (!pos_on_q) begin
        pos_ilim_step <= 4'h1;
        ramp_cnt_q    <= 32'h0;
      end else if (pos_ilim_step != 4'(ILIM_STEPS)) begin
        if (ramp_cnt_q + 32'h1 >= ramp_period) begin
          ramp_cnt_q    <= 32'h0;
          pos_ilim_step <= pos_ilim_step + 4'h1;
        end else begin
          ramp_cnt_q <= ramp_cnt_q + 32'h1;
        end
      end
    end
  end

  // Gate regulation targets and backlight enable
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      gate_high_level <= 6'h00;
      gate_low_level  <= 6'h00;
      bias_good_q     <= 1'b0;
      backlight_en    <= 1'b0;
    end else begin
      gate_high_level <= gate_high_level_in;
      gate_low_level  <= gate_low_level_in;
      bias_good_q     <= (state_q == ST_ON) && rail_power_good[RAIL_POS]
                         && (unipolar || rail_power_good[RAIL_NEG])
                         && rail_power_good[RAIL_GL] && rail_power_good[RAIL_GH];
      backlight_en    <= bias_good_q && (state_q == ST_ON) && start_req
                         && led_supply_ok && driver_supply_ok;
    end
  end

  // Power-fail indicator, set wins over release
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pf_q <= 1'b0;
    end else if (core_rail_ok && (order_config_q[PF_THRESH_SEL_BIT] ? main_below_2v4
                                                                    : main_below_2v5)) begin
      pf_q <= 1'b1;
    end else if (!core_rail_ok || !(main_below_2v4 || main_below_2v5)) begin
      pf_q <= 1'b0;
    end
  end

  assign power_fail_o  = 1'b0;
  assign power_fail_oe = pf_q;

endmodule

// ---- dv/tft_bias_properties.sv ----
`timescale 1ns/1ns
module tft_bias_properties
  import bias_seq_pkg::*;
(
  input wire logic       clock,
  input wire logic       reset_n,
  input wire logic       enable_pin,
  input wire logic       main_supply_ok,
  input wire logic       core_rail_ok,
  input wire logic       main_below_2v5,
  input wire logic       main_below_2v4,
  input wire logic       led_supply_ok,
  input wire logic       driver_supply_ok,
  input wire logic       boost_soft_start_done,
  input wire logic [3:0] rail_power_good,
  input wire logic [5:0] gate_high_level_in,
  input wire logic [5:0] gate_low_level_in,
  input wire logic [5:0] gate_high_level,
  input wire logic [5:0] gate_low_level,
  input wire logic       boost_rail_en,
  input wire logic [3:0] rail_en,
  input wire logic [3:0] pos_ilim_step,
  input wire logic       core_rail_en,
  input wire logic       backlight_en,
  input wire logic       power_fail_o,
  input wire logic       power_fail_oe,
  input wire logic       seq_busy
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  // Supply loss drops every bias rail and the boost rail on the next cycle
  chk_off_no_supply: assert property ((!main_supply_ok || !core_rail_ok) |=>
    (rail_en == 4'h0 && !boost_rail_en)) else $error("rails on without supply");
  // Bias rails only ride on a running boost rail
  chk_rails_need_boost: assert property (rail_en != 4'h0 |-> boost_rail_en)
    else $error("rail on without boost");
  chk_first_after_ss: assert property ($rose(rail_en != 4'h0) |->
    $past(boost_soft_start_done)) else $error("rail before soft-start done");
  // Waiting for soft-start counts as a running sequence
  chk_busy_wait: assert property (boost_rail_en && rail_en == 4'h0 &&
    !boost_soft_start_done |-> seq_busy) else $error("busy low in boost wait");
  // Backlight only after the bias rails are good and supplies pass lockout
  chk_light_needs_pg: assert property ($rose(backlight_en) |->
    $past(rail_power_good[RAIL_POS] && rail_power_good[RAIL_GL] &&
    rail_power_good[RAIL_GH])) else $error("backlight before power good");
  chk_light_supplies: assert property ((!(led_supply_ok && driver_supply_ok))[*2] |->
    !backlight_en) else $error("backlight with supply lockout");
  // Current limit climbs one step at a time up to eight
  chk_ilim_steps: assert property ((pos_ilim_step != $past(pos_ilim_step) &&
    pos_ilim_step != 4'h0) |-> (pos_ilim_step == $past(pos_ilim_step) + 4'h1 &&
    pos_ilim_step <= 4'h8)) else $error("current limit step wrong");
  // Core rail drops only on the enable pin path
  chk_core_by_pin: assert property ($fell(core_rail_en) |-> !enable_pin)
    else $error("core rail off with enable high");
  // Power fail follows the comparators while core rail is up
  chk_pf_set: assert property ((main_below_2v5 && main_below_2v4 && core_rail_ok) |=>
    (power_fail_oe && !power_fail_o)) else $error("power fail not asserted");
  chk_pf_clear: assert property ((!main_below_2v5 && !main_below_2v4) |=>
    !power_fail_oe) else $error("power fail stuck");
  // Gate targets are separate registered copies
  chk_gate_copy: assert property ($past(reset_n) |->
    (gate_high_level == $past(gate_high_level_in) &&
    gate_low_level == $past(gate_low_level_in))) else $error("gate level copy wrong");
endmodule

bind tft_bias_power_sequencer tft_bias_properties u_props (.*);

// ---- dv/bias_rail_model.sv ----
`timescale 1ns/1ns
module bias_rail_model (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       slow,
  input  wire logic       boost_rail_en,
  input  wire logic [3:0] rail_en,
  output logic            boost_soft_start_done,
  output logic      [3:0] rail_power_good
);
  logic [5:0] ss_q;

  // Boost soft-start timer, restarts whenever boost is off
  always_ff @(posedge clock) begin
    if (!reset_n || !boost_rail_en) begin
      ss_q <= 6'h00;
    end else if (ss_q != 6'h3f) begin
      ss_q <= ss_q + 6'h01;
    end
  end
  assign boost_soft_start_done = ss_q >= (slow ? 6'h28 : 6'h03);

  // Rails report good one cycle after their enable
  always_ff @(posedge clock) begin
    rail_power_good <= reset_n ? rail_en : 4'h0;
  end
endmodule

// ---- dv/tft_bias_power_sequencer_tb_top.sv ----
`timescale 1ns/1ns
`define CHK(a, e) \
  begin \
    checks_done++; \
    if ((a) !== (e)) begin \
      num_errors++; \
      $display("ERROR %0t got %h exp %h", $time, (a), (e)); \
    end \
  end
module tft_bias_power_sequencer_tb_top;
  import bias_seq_pkg::*;
  localparam int CPM = 20;
  typedef struct packed {logic we; logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic            clock, reset_n, reg_write, reg_read, launch, nv_store_cmd, enable_pin;
  logic            main_supply_ok, core_rail_ok, main_below_2v5, main_below_2v4, slow;
  logic            led_supply_ok, driver_supply_ok, boost_soft_start_done, boost_rail_en;
  logic            core_rail_en, backlight_en, power_fail_o, power_fail_oe, seq_busy;
  logic [7:0]      reg_addr, reg_wdata, reg_rdata, d;
  logic [NV_W-1:0] nv_image_in, nv_image;
  logic [3:0]      rail_power_good, rail_en, pos_ilim_step;
  logic [5:0]      gate_high_level_in, gate_low_level_in, gate_high_level, gate_low_level;
  int              num_errors, checks_done, cyc, n;
  // Slot masks per order, slot 0 in the low nibble
  logic [15:0]     slots [8] = '{16'h8421, 16'h4821, 16'h8412, 16'h4812,
                                 16'h8142, 16'h1284, 16'h0843, 16'h0483};
  // Reset values, write masks and an unmapped address
  row_t            rows [8] = '{'{1'b0, 8'h07, 8'h00, 8'h00}, '{1'b0, 8'h08, 8'h00, 8'h00},
                                '{1'b0, 8'h09, 8'h00, 8'h02}, '{1'b1, 8'h07, 8'hff, 8'h01},
                                '{1'b1, 8'h08, 8'hc5, 8'hc5}, '{1'b1, 8'h09, 8'hff, 8'h3f},
                                '{1'b1, 8'h0a, 8'h55, 8'h00}, '{1'b1, 8'h07, 8'h00, 8'h00}};

  tft_bias_power_sequencer #(.CYCLES_PER_MS(CPM)) uut (.*);
  bias_rail_model model (.*);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Cycle ceiling against hangs
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask

  task automatic do_reset();
    reset_n <= 1'b0;
    tick(10);
    reset_n <= 1'b1;
    tick(2);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
  endtask

  // Cycles until the rail enables change
  task automatic wait_en();
    logic [3:0] p;
    p = rail_en;
    n = 0;
    while (rail_en === p && n < 400) begin
      @(posedge clock);
      n++;
    end
  endtask

  // One full power-up and power-down in order o with step timing t
  task automatic run_seq(input logic [2:0] o, input logic [7:0] t, input logic u);
    logic [15:0] m;
    logic [3:0]  c;
    logic [3:0]  s;
    int          g;
    m = u ? (slots[o] & 16'hdddd) : slots[o];
    c = 4'h0;
    wr(PANEL_BIAS_CONFIG_OFS, {7'h00, u});
    wr(ORDER_CONFIG_OFS, {2'b00, t[7:6], 1'b0, o});
    wr(STEP_TIMING_OFS, t);
    launch <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      s = m[4*k +: 4];
      if (s != 4'h0) begin
        wait_en();
        c = c | s;
        `CHK(rail_en, c)
        g = (k == 0) ? 0 : int'(t[2*k-2 +: 2]) * CPM;
        if (k > 0) begin
          `CHK(n <= g + 3 && n + CPM > g, 1'b1)
        end
      end
    end
    tick(40);
    `CHK(backlight_en, 1'b1)
    `CHK(pos_ilim_step, 4'h8)
    rd(PANEL_BIAS_CONFIG_OFS);
    `CHK(d, {c, 3'b000, u})
    launch <= 1'b0;
    for (int k = 3; k >= 0; k--) begin
      s = m[4*k +: 4];
      if (s != 4'h0) begin
        wait_en();
        c = c & ~s;
        `CHK(rail_en, c)
        if (k < 3 && m[4*k+4 +: 4] != 4'h0) begin
          g = int'(t[2*k +: 2]);
          g = (g == 0) ? CPM : g * CPM;
          `CHK(n <= g + 3 && n + CPM > g, 1'b1)
        end
      end
    end
    tick(5);
    `CHK(boost_rail_en, 1'b0)
    `CHK(core_rail_en, 1'b1)
    `CHK({seq_busy, backlight_en}, 2'b00)
  endtask

  initial begin
    {reg_write, reg_read, launch, nv_store_cmd, slow, main_below_2v5, main_below_2v4} <= 7'h00;
    {enable_pin, main_supply_ok, core_rail_ok, led_supply_ok, driver_supply_ok} <= 5'h1f;
    reg_addr <= 8'h00;
    reg_wdata <= 8'h00;
    nv_image_in <= 25'h0020000;
    gate_high_level_in <= 6'h2a;
    gate_low_level_in <= 6'h15;
    do_reset();
    `CHK({gate_high_level, gate_low_level}, 12'h a95)
    foreach (rows[i]) begin
      if (rows[i].we) begin
        wr(rows[i].a, rows[i].d);
      end
      rd(rows[i].a);
      `CHK(d, rows[i].e)
    end
    // Power-fail threshold select, then the default threshold
    wr(ORDER_CONFIG_OFS, 8'h0a);
    main_below_2v5 <= 1'b1;
    tick(3);
    `CHK(power_fail_oe, 1'b0)
    main_below_2v4 <= 1'b1;
    tick(3);
    main_below_2v4 <= 1'b0;
    tick(3);
    `CHK(power_fail_oe, 1'b1)
    main_below_2v5 <= 1'b0;
    wr(ORDER_CONFIG_OFS, 8'h02);
    `CHK(power_fail_oe, 1'b0)
    main_below_2v5 <= 1'b1;
    tick(3);
    `CHK(power_fail_oe, 1'b1)
    main_below_2v5 <= 1'b0;
    // Every order, then gaps with slow boost and slowest ramp, then unipolar
    for (int o = 0; o < 8; o++) begin
      run_seq(3'(o), 8'h00, 1'b0);
    end
    slow <= 1'b1;
    run_seq(3'h2, 8'hf9, 1'b0);
    slow <= 1'b0;
    run_seq(3'h0, 8'h00, 1'b1);
    // Supply lockouts while on
    wr(PANEL_BIAS_CONFIG_OFS, 8'h00);
    launch <= 1'b1;
    tick(40);
    led_supply_ok <= 1'b0;
    tick(3);
    `CHK(backlight_en, 1'b0)
    main_supply_ok <= 1'b0;
    tick(2);
    `CHK({rail_en, boost_rail_en}, 5'h00)
    {led_supply_ok, main_supply_ok} <= 2'b11;
    tick(40);
    // Enable pin off: hold, core off, then restart
    enable_pin <= 1'b0;
    tick(3950);
    `CHK({rail_en, core_rail_en}, 5'h01)
    tick(200);
    `CHK(core_rail_en, 1'b0)
    enable_pin <= 1'b1;
    tick(40);
    `CHK({core_rail_en, boost_rail_en}, 2'b11)
    launch <= 1'b0;
    tick(100);
    // Store config, then autorun from the stored image
    wr(ORDER_CONFIG_OFS, 8'h05);
    nv_store_cmd <= 1'b1;
    @(posedge clock);
    nv_store_cmd <= 1'b0;
    tick(3);
    `CHK(nv_image[NV_ORDER_LSB +: 8], 8'h05)
    nv_image_in <= 25'h1050000;
    do_reset();
    rd(ORDER_CONFIG_OFS);
    `CHK(d, 8'h05)
    tick(20);
    `CHK(boost_rail_en, 1'b1)
    close_out();
  end
endmodule
